//--- verilog/sfp_port.sv
// Serial flash program port: serial slave decoding flash commands.
// Assumes a flash controller answering o_fl_req with i_fl_done.
`timescale 1ns/10ps
module sfp_port
  import sfp_pkg::*;
#(
  parameter int             AW        = 18,
  parameter logic [AW-1:0]  FLASH_TOP = '1
)
(
  input  wire logic          i_core_clk,           // 40 MHz core clock
  input  wire logic          i_rstn,               // Async reset, low
  input  wire logic          i_port_serial_clock,  // Serial clock pin
  input  wire logic          i_port_chip_select_n, // Select pin, low
  input  wire logic          i_sdi,                // Serial data in
  output logic               o_sdo,                // Serial data out
  output logic               o_sdo_oe,             // Data out enable
  input  wire logic          i_sec_strap,          // Secure at reset
  output logic               o_fl_req,             // Flash op pulse
  output sfp_flop_t          o_fl_op,              // Flash op kind
  output logic [AW-1:0]      o_fl_addr,            // Flash byte address
  output logic [31:0]        o_fl_wdata,           // Program word
  input  wire logic          i_fl_done,            // Flash op finished
  input  wire logic [7:0]    i_fl_rdata,           // Read byte at done
  input  wire logic          i_fl_err,             // Error at done
  output logic               o_fclk,               // Flash SM clock
  output logic               o_chip_reset,         // Chip reset pulse
  output logic               o_secure_clear,       // Drop security
  output logic               o_port_en             // Port enabled
);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rs_q;
  logic       rstn;
  logic [2:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] sdi_s;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rs_q <= 2'b00;
    else
      rs_q <= {rs_q[0], 1'b1};
  end
  assign rstn = rs_q[1];

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_s <= 3'b000;
      cs_s  <= 2'b11;
      sdi_s <= 2'b00;
    end
    else
    begin
      sck_s <= {sck_s[1:0], i_port_serial_clock};
      cs_s  <= {cs_s[0], i_port_chip_select_n};
      sdi_s <= {sdi_s[0], i_sdi};
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] a);
    nxt = (a == FLASH_TOP) ? '0 : a + AW'(1);
  endfunction

  sfp_phase_t    ph_q, ph_d;
  sfp_flop_t     op_q, op_d;
  logic [2:0]    bit_q, bit_d;
  logic [7:0]    rx_q, rx_d, tx_q, tx_d, cmd_q, cmd_d;
  logic [7:0]    buf_q, buf_d, cfg_q, cfg_d;
  logic [1:0]    ac_q, ac_d, wc_q, wc_d, init_q, init_d;
  logic [15:0]   sh_q, sh_d;
  logic [23:0]   wb_q, wb_d;
  logic [8:0]    pc_q, pc_d;
  logic [AW-1:0] ad_q, ad_d, fa_q, fa_d;
  logic [31:0]   wd_q, wd_d;
  logic          oe_q, oe_d, first_q, first_d, req_q, req_d;
  logic          pend_q, pend_d, busy_q, busy_d, wen_q, wen_d;
  logic          werr_q, werr_d, cfgld_q, cfgld_d;
  logic          secure_q, secure_d, be_q, be_d, en_q, en_d;
  logic          crst_q, crst_d, sclr_q, sclr_d;
  logic          rise, fall, sel, byte_end;
  logic [7:0]    rxb, stat;
  logic [AW-1:0] a_new;

  assign rise     = sck_s[1] && !sck_s[2];
  assign fall     = !sck_s[1] && sck_s[2];
  assign sel      = !cs_s[1] && en_q;
  assign rxb      = {rx_q[6:0], sdi_s[1]};
  assign byte_end = sel && rise && (bit_q == 3'h7);
  assign a_new    = AW'({sh_q, rxb});
  always_comb
  begin
    stat            = 8'h00;
    stat[ST_SECURE] = secure_q;
    stat[ST_WERR]   = werr_q;
    stat[ST_CFGLD]  = cfgld_q;
    stat[ST_WREN]   = wen_q;
    stat[ST_BUSY]   = busy_q;
  end

  // ==========================================================
  // Command sequencer
  always_comb
  begin
    ph_d = ph_q;     op_d = op_q;       bit_d = bit_q;
    rx_d = rx_q;     tx_d = tx_q;       cmd_d = cmd_q;
    buf_d = buf_q;   cfg_d = cfg_q;     ac_d = ac_q;
    wc_d = wc_q;     init_d = init_q;   sh_d = sh_q;
    wb_d = wb_q;     pc_d = pc_q;       ad_d = ad_q;
    fa_d = fa_q;     wd_d = wd_q;       oe_d = oe_q;
    first_d = first_q; pend_d = pend_q; busy_d = busy_q;
    wen_d = wen_q;   werr_d = werr_q;   cfgld_d = cfgld_q;
    secure_d = secure_q; be_d = be_q;   en_d = en_q;
    req_d = 1'b0;    crst_d = 1'b0;     sclr_d = 1'b0;

    // Strap and select caught once the synchronisers settle
    if (init_q != 2'h3)
      init_d = init_q + 2'h1;
    if (init_q == 2'h2)
    begin
      en_d     = !cs_s[1];
      secure_d = i_sec_strap;
    end

    if (i_fl_done && pend_q)
    begin
      pend_d = 1'b0;
      if (op_q == FL_READ)
      begin
        if (first_q)
        begin
          tx_d    = i_fl_rdata;
          first_d = 1'b0;
          ad_d    = nxt(ad_q);
          fa_d    = nxt(ad_q);
          req_d   = 1'b1;
          pend_d  = 1'b1;
        end
        else
          buf_d = i_fl_rdata;
      end
      else
      begin
        if (i_fl_err)
          werr_d = 1'b1;
        if (op_q == FL_BERASE)
          be_d = 1'b1;
      end
    end

    // Write finishes once deselected with nothing outstanding
    if (busy_q && !sel && !pend_q && !req_q)
    begin
      busy_d = 1'b0;
      wen_d  = 1'b0;
    end

    if (!sel)
    begin
      ph_d  = PH_CMD;
      bit_d = 3'h0;
      oe_d  = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        rx_d  = rxb;
        bit_d = bit_q + 3'h1;
      end
      if (fall && bit_q != 3'h0)
        tx_d = {tx_q[6:0], 1'b0};
    end

    if (byte_end)
    begin
      case (ph_q)
        PH_CMD:
        begin
          cmd_d = rxb;
          ac_d  = 2'h0;
          ph_d  = PH_IGN;
          if (!busy_q || rxb == OP_RD_STATUS)
          begin
            case (rxb)
              OP_RD_STATUS:
              begin
                tx_d   = stat;
                werr_d = 1'b0;
                oe_d   = 1'b1;
                ph_d   = PH_STAT;
              end
              OP_WR_EN:  wen_d = 1'b1;
              OP_WR_DIS: wen_d = 1'b0;
              OP_READ, OP_FAST_READ:
                if (!secure_q)
                  ph_d = PH_ADDR;
              OP_PAGE_PROG, OP_SECT_ERASE:
                if (!secure_q && wen_q && cfgld_q)
                  ph_d = PH_ADDR;
              OP_BULK_ERASE:
                if (wen_q && cfgld_q)
                begin
                  op_d   = FL_BERASE;
                  req_d  = 1'b1;
                  pend_d = 1'b1;
                  busy_d = 1'b1;
                end
              OP_WR_CFG:
                if (wen_q && !cfgld_q)
                begin
                  ph_d   = PH_CFG;
                  busy_d = 1'b1;
                end
              OP_CHIP_RST:
              begin
                crst_d = 1'b1;
                sclr_d = be_q;
              end
              default: ph_d = PH_IGN;
            endcase
          end
        end
        PH_ADDR:
        begin
          sh_d = {sh_q[7:0], rxb};
          ac_d = ac_q + 2'h1;
          if (ac_q == 2'h2)
          begin
            ad_d = a_new;
            fa_d = a_new;
            case (cmd_q)
              OP_READ, OP_FAST_READ:
              begin
                op_d    = FL_READ;
                req_d   = 1'b1;
                pend_d  = 1'b1;
                oe_d    = 1'b1;
                first_d = (cmd_q == OP_READ);
                ph_d    = (cmd_q == OP_READ) ? PH_RDATA
                                             : PH_DUMMY;
              end
              OP_PAGE_PROG:
              begin
                busy_d = 1'b1;
                pc_d   = 9'h000;
                wc_d   = 2'h0;
                ph_d   = PH_PDATA;
              end
              default:
              begin
                op_d   = FL_SERASE;
                fa_d   = {a_new[AW-1:SECT_LSB],
                          SECT_LSB'(0)};
                req_d  = 1'b1;
                pend_d = 1'b1;
                busy_d = 1'b1;
                ph_d   = PH_IGN;
              end
            endcase
          end
        end
        PH_DUMMY, PH_RDATA:
        begin
          tx_d   = buf_q;
          ad_d   = nxt(ad_q);
          fa_d   = nxt(ad_q);
          op_d   = FL_READ;
          req_d  = 1'b1;
          pend_d = 1'b1;
          ph_d   = PH_RDATA;
        end
        PH_STAT:
        begin
          tx_d   = stat;
          werr_d = 1'b0;
        end
        PH_PDATA:
          if (pc_q != PAGE_BYTES)
          begin
            pc_d = pc_q + 9'h001;
            wc_d = wc_q + 2'h1;
            wb_d = {wb_q[15:0], rxb};
            if (wc_q == 2'h3)
            begin
              wd_d   = {wb_q, rxb};
              op_d   = FL_PROG;
              fa_d   = ad_q;
              req_d  = 1'b1;
              pend_d = 1'b1;
              ad_d   = {ad_q[AW-1:PAGE_LSB],
                        ad_q[PAGE_LSB-1:WORD_LSB] + 6'h01,
                        2'b00};
            end
          end
        PH_CFG:
        begin
          cfg_d   = rxb;
          cfgld_d = 1'b1;
          ph_d    = PH_IGN;
        end
        default: ph_d = PH_IGN;
      endcase
    end
    if (i_fl_done && pend_q && op_q != FL_READ && i_fl_err)
      werr_d = 1'b1;
  end

  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_q <= PH_CMD;  op_q <= FL_READ;  bit_q <= 3'h0;
      rx_q <= 8'h00;   tx_q <= 8'h00;    cmd_q <= 8'h00;
      buf_q <= 8'h00;  cfg_q <= CFG_RST; ac_q <= 2'h0;
      wc_q <= 2'h0;    init_q <= 2'h0;   sh_q <= 16'h0000;
      wb_q <= 24'h000000; pc_q <= 9'h000; ad_q <= '0;
      fa_q <= '0;      wd_q <= 32'h00000000; oe_q <= 1'b0;
      first_q <= 1'b0; pend_q <= 1'b0;   busy_q <= 1'b0;
      wen_q <= 1'b0;   werr_q <= 1'b0;   cfgld_q <= 1'b0;
      secure_q <= 1'b1; be_q <= 1'b0;    en_q <= 1'b0;
      req_q <= 1'b0;   crst_q <= 1'b0;   sclr_q <= 1'b0;
    end
    else
    begin
      ph_q <= ph_d;    op_q <= op_d;     bit_q <= bit_d;
      rx_q <= rx_d;    tx_q <= tx_d;     cmd_q <= cmd_d;
      buf_q <= buf_d;  cfg_q <= cfg_d;   ac_q <= ac_d;
      wc_q <= wc_d;    init_q <= init_d; sh_q <= sh_d;
      wb_q <= wb_d;    pc_q <= pc_d;     ad_q <= ad_d;
      fa_q <= fa_d;    wd_q <= wd_d;     oe_q <= oe_d;
      first_q <= first_d; pend_q <= pend_d; busy_q <= busy_d;
      wen_q <= wen_d;  werr_q <= werr_d; cfgld_q <= cfgld_d;
      secure_q <= secure_d; be_q <= be_d; en_q <= en_d;
      req_q <= req_d;  crst_q <= crst_d; sclr_q <= sclr_d;
    end
  end

  sfp_fclk_div u_div (
    .i_core_clk (i_core_clk),
    .i_rstn     (rstn),
    .i_run      (cfgld_q),
    .i_pre      (cfg_q[CFG_PRE_BIT]),
    .i_div      (cfg_q[CFG_DIV_HI:0]),
    .o_fclk     (o_fclk)
  );

  assign o_sdo          = tx_q[7];
  assign o_sdo_oe       = oe_q;
  assign o_fl_req       = req_q;
  assign o_fl_op        = op_q;
  assign o_fl_addr      = fa_q;
  assign o_fl_wdata     = wd_q;
  assign o_chip_reset   = crst_q;
  assign o_secure_clear = sclr_q;
  assign o_port_en      = en_q;

  // ==========================================================
  // Checks
  logic [AW-1:0] lpa_q;
  always_ff @(posedge i_core_clk or negedge rstn)
  begin
    if (!rstn)
      lpa_q <= '0;
    else if (req_q && op_q == FL_PROG)
      lpa_q <= fa_q;
  end

  cfg_write_once_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) cfgld_q |=> $stable(cfg_q) && cfgld_q)
    else $error("clock config changed after load");
  secure_reject_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (secure_q && req_q) |-> op_q == FL_BERASE)
    else $error("flash op issued while secure");
  read_step_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (byte_end && ph_q == PH_RDATA)
    |=> req_q && fa_q == nxt($past(ad_q)))
    else $error("read address did not step or wrap");
  page_wrap_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (req_q && op_q == FL_PROG && ph_q == PH_PDATA
      && pc_q > 9'h004)
    |-> fa_q[AW-1:PAGE_LSB] == lpa_q[AW-1:PAGE_LSB]
      && fa_q[PAGE_LSB-1:0] == lpa_q[PAGE_LSB-1:0] + 8'h04)
    else $error("program address left its page");
  sector_base_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (req_q && op_q == FL_SERASE)
    |-> fa_q[SECT_LSB-1:0] == '0)
    else $error("sector erase address not region base");
  error_set_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn)
    (i_fl_done && pend_q && i_fl_err && op_q != FL_READ) |=> werr_q)
    else $error("write error flag not set");
  busy_only_status_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (byte_end && ph_q == PH_CMD && busy_q
      && rxb != OP_RD_STATUS) |=> ph_q == PH_IGN && !req_q)
    else $error("command accepted while busy");
  wen_clear_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) $fell(busy_q) |-> !wen_q)
    else $error("write enable kept after write");
  status_clear_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (byte_end && ph_q == PH_CMD && !busy_q
      && rxb == OP_RD_STATUS && !(i_fl_done && i_fl_err))
    |=> !werr_q ##0 tx_q[ST_WERR] == $past(werr_q))
    else $error("status read did not clear error");
  deselect_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) !sel |=> ph_q == PH_CMD && !o_sdo_oe)
    else $error("deselect did not end command");
  msb_shift_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (sel && fall && bit_q != 3'h0
      && !(i_fl_done && pend_q && first_q))
    |=> o_sdo == $past(tx_q[6]))
    else $error("data out not shifted msb first");
  chip_reset_a: assert property (@(posedge i_core_clk)
    disable iff (!rstn) (byte_end && ph_q == PH_CMD && !busy_q
      && rxb == OP_CHIP_RST) |=> o_chip_reset && o_secure_clear == be_q)
    else $error("reset command mishandled");

endmodule

//--- verilog/sfp_pkg.sv
// Constants for the serial flash program port.
// Assumes a single core clock; no other package is needed.
package sfp_pkg;

  // ==========================================================
  // Command opcodes
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_FAST_READ  = 8'h0B;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hD8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  localparam logic [7:0] OP_CHIP_RST   = 8'hB9;
  localparam logic [7:0] OP_WR_CFG     = 8'h01;
  localparam logic [7:0] OP_RD_STATUS  = 8'h05;
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;

  // ==========================================================
  // Clock configuration fields
  localparam int         CFG_PRE_BIT = 6;
  localparam int         CFG_DIV_HI  = 5;
  localparam logic [2:0] PRE_LAST    = 3'h7;
  localparam logic [7:0] CFG_RST     = 8'h00;

  // ==========================================================
  // Status bit positions
  localparam int ST_SECURE = 7;
  localparam int ST_WERR   = 6;
  localparam int ST_CFGLD  = 5;
  localparam int ST_WREN   = 1;
  localparam int ST_BUSY   = 0;

  // ==========================================================
  // Flash geometry
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam int         SECT_LSB   = 11;
  localparam int         PAGE_LSB   = 8;
  localparam int         WORD_LSB   = 2;

  // ==========================================================
  // Flash operations and command phases
  typedef enum logic [1:0] {
    FL_READ   = 2'b00,
    FL_PROG   = 2'b01,
    FL_SERASE = 2'b10,
    FL_BERASE = 2'b11
  } sfp_flop_t;

  typedef enum logic [2:0] {
    PH_CMD   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_DUMMY = 3'b010,
    PH_RDATA = 3'b011,
    PH_PDATA = 3'b100,
    PH_CFG   = 3'b101,
    PH_STAT  = 3'b110,
    PH_IGN   = 3'b111
  } sfp_phase_t;

endpackage

//--- verilog/sfp_fclk_div.sv
// Flash state machine clock divider.
// Assumes a synchronous active-low reset from the parent.
`timescale 1ns/10ps
module sfp_fclk_div
  import sfp_pkg::*;
(
  input  wire logic       i_core_clk, // Core clock
  input  wire logic       i_rstn,     // Synced reset, active low
  input  wire logic       i_run,      // Configuration loaded
  input  wire logic       i_pre,      // Divide-by-8 prescaler on
  input  wire logic [5:0] i_div,      // Divider value
  output logic            o_fclk      // Divided flash clock
);

  logic [2:0] pre_q, pre_d;
  logic [5:0] div_q, div_d;
  logic       clk_q, clk_d;
  logic       tick;

  assign tick = !i_pre || (pre_q == PRE_LAST);

  // ==========================================================
  // Half period is (div+1) ticks of sys or sys/8
  always_comb
  begin
    pre_d = pre_q;
    div_d = div_q;
    clk_d = clk_q;
    if (!i_run)
    begin
      pre_d = 3'h0;
      div_d = 6'h00;
      clk_d = 1'b0;
    end
    else
    begin
      pre_d = i_pre ? pre_q + 3'h1 : 3'h0;
      if (tick)
      begin
        if (div_q == i_div)
        begin
          div_d = 6'h00;
          clk_d = !clk_q;
        end
        else
          div_d = div_q + 6'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pre_q <= 3'h0;
      div_q <= 6'h00;
      clk_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      div_q <= div_d;
      clk_q <= clk_d;
    end
  end

  assign o_fclk = clk_q;

  // ==========================================================
  // Cycles between toggles checked against the formula
  logic [9:0] hc_q;
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      hc_q <= 10'h000;
    else if (!i_run || clk_d != clk_q)
      hc_q <= 10'h000;
    else
      hc_q <= hc_q + 10'h001;
  end

  half_period_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rstn)
    (i_run && $stable(i_run) && $stable(i_div) && $stable(i_pre)
     && clk_d != clk_q && $past(clk_d == clk_q))
    |-> hc_q == 10'((i_div + 10'h1) * (i_pre ? 10'h8 : 10'h1) - 1))
    else $error("flash clock half period wrong");

endmodule

//--- sim/sfp_master_model.sv
// Serial master model that drives the program port pins.
// Assumes the core clock; pins change just after its rising edge.
`timescale 1ns/10ps
module sfp_master_model #(parameter int H = 8)
(
  input  wire logic i_clk, // Core clock
  input  wire logic i_sdo, // Resolved data wire
  output logic      o_sck, // Serial clock
  output logic      o_csn, // Select, low
  output logic      o_sdi  // Data to port
);
  logic pol = 1'b0;
  initial
  begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b0;
  end
  // ==========================================================
  // Frame tasks
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic sel(input logic m);
    pol = m;
    o_sck = m;
    tick(H);
    o_csn = 1'b0;
    tick(H);
  endtask
  task automatic desel();
    o_csn = 1'b1;
    o_sdi = ~o_sdi;
    tick(2 * H);
  endtask
  task automatic xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      o_sck = 1'b0;
      o_sdi = t[i];
      tick(H);
      o_sck = 1'b1;
      r = {r[6:0], i_sdo};
      tick(H);
    end
    o_sck = pol;
    tick(2 * H);
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench for the serial flash program port.
// Assumes sfp_pkg; a flash controller model answers each request.
`timescale 1ns/10ps
module testbench;
  import sfp_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, strap = 1'b0, done = 1'b0, ferr = 1'b0;
  logic [7:0] rdat = 8'h00, r, c;
  logic sdo, oe, req, fclk, crst, sclr, pen;
  logic [17:0] fad, pa;
  logic [31:0] fwd, ew [3];
  logic [51:0] fq [$];
  sfp_flop_t fop;
  wire sck, csn, sdi;
  wire sdw = oe ? sdo : 1'bz;
  int errors = 0, comparisons = 0, seed = 47613;
  int sec, werr, cfg, wen, emode = 0, nrst = 0, nclr = 0;
  sfp_port DUT (.i_core_clk(clk), .i_rstn(rstn), .i_port_serial_clock(sck),
    .i_port_chip_select_n(csn), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(oe),
    .i_sec_strap(strap), .o_fl_req(req), .o_fl_op(fop), .o_fl_addr(fad),
    .o_fl_wdata(fwd), .i_fl_done(done), .i_fl_rdata(rdat), .i_fl_err(ferr),
    .o_fclk(fclk), .o_chip_reset(crst), .o_secure_clear(sclr),
    .o_port_en(pen));
  sfp_master_model m (.i_clk(clk), .i_sdo(sdw), .o_sck(sck), .o_csn(csn),
    .o_sdi(sdi));
  initial forever #12.5 clk = ~clk;
  // ==========================================================
  // Flash controller model
  function automatic logic [7:0] fd(input logic [17:0] a);
    return a[7:0] ^ a[17:10] ^ 8'hA5;
  endfunction
  task automatic flash_ans(input logic [17:0] a);
    repeat (emode[1] ? 1000 : 3) @(posedge clk);
    #1;
    done = 1'b1;
    rdat = fd(a);
    ferr = emode[0];
    @(posedge clk);
    #1;
    done = 1'b0;
  endtask
  always @(posedge clk)
  begin
    if (req === 1'b1)
    begin
      fq.push_back({fop, fad, fwd});
      fork
        flash_ans(fad);
      join_none
    end
    if (crst === 1'b1) nrst++;
    if (sclr === 1'b1) nclr++;
  end
  // ==========================================================
  // Bench tasks
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b);
    m.xfer(b, r);
  endtask
  task automatic cmd(input logic md, input logic [7:0] op,
                     input logic [23:0] a, input int na);
    m.sel(md);
    tx(op);
    for (int i = 2; i >= 3 - na; i--) tx(a[i*8 +: 8]);
  endtask
  function automatic logic [7:0] est();
    return {sec[0], werr[0], cfg[0], 3'h0, wen[0], 1'b0};
  endfunction
  task automatic rdst();
    cmd(1'b0, OP_RD_STATUS, 24'h0, 0);
    m.xfer(8'h00, r);
    m.desel();
  endtask
  task automatic idle();
    for (int i = 0; i < 40; i++)
    begin
      rdst();
      if (r[0] === 1'b0) break;
    end
    check(r, est());
    werr = 0;
  endtask
  task automatic wren();
    cmd(1'b0, OP_WR_EN, 24'h0, 0);
    m.desel();
    wen = 1;
  endtask
  task automatic half(input logic [7:0] v);
    int n;
    @(negedge fclk);
    @(posedge fclk);
    for (n = 0; n < 2000; n++)
    begin
      @(posedge clk);
      if (fclk !== 1'b1) break;
    end
    check(n, (v[5:0] + 1) * (v[6] ? 8 : 1));
  endtask
  task automatic rd(input logic f, input logic md, input logic [17:0] a,
                    input int n);
    cmd(md, f ? OP_FAST_READ : OP_READ, {6'h0, a}, 3);
    if (f) tx(8'h00);
    for (int i = 0; i < n; i++)
    begin
      m.xfer(8'h00, r);
      check(r, sec ? 8'hZZ : fd(a + 18'(i)));
    end
    m.desel();
  endtask
  task automatic rst(input logic cs, input logic s);
    m.tick(1);
    m.o_csn = cs;
    strap = s;
    rstn = 1'b0;
    m.tick(12);
    rstn = 1'b1;
    m.tick(20);
    check(pen, !cs);
    m.o_csn = 1'b1;
    m.tick(8);
    {sec, werr, cfg, wen} = {32'(s), 96'h0};
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    rst(1'b0, 1'b0);
    rdst();
    check(r, est());
    c = 8'h4C;
    wren();
    cmd(1'b0, OP_WR_CFG, 24'h0, 0);
    tx(c);
    m.desel();
    {cfg, wen} = {32'd1, 32'd0};
    idle();
    half(c);
    wren();
    cmd(1'b0, OP_WR_CFG, 24'h0, 0);
    tx(8'($random(seed)) & 8'h7F);
    m.desel();
    rdst();
    check(r, est());
    half(c);
    cmd(1'b0, OP_WR_DIS, 24'h0, 0);
    m.desel();
    wen = 0;
    rdst();
    check(r, est());
    rd(1'b0, 1'b0, 18'h3FFFE, 3);
    rd(1'b1, 1'b1, 18'($random(seed)), 4);
    wren();
    fq.delete();
    emode = 1;
    pa = {8'($random(seed)), 10'h0F8};
    cmd(1'b0, OP_PAGE_PROG, {6'h0, pa}, 3);
    for (int i = 0; i < 3; i++)
    begin
      ew[i] = $random(seed);
      for (int j = 3; j >= 0; j--) tx(ew[i][j*8 +: 8]);
    end
    m.desel();
    {werr, wen} = {32'd1, 32'd0};
    idle();
    check(fq.size(), 3);
    for (int i = 0; i < 3; i++)
      check(fq[i], {FL_PROG, pa[17:8], pa[7:0] + 8'(i * 4), ew[i]});
    // ==========================================================
    // Slow flash: only status read accepted while busy
    wren();
    emode = 2;
    fq.delete();
    cmd(1'b0, OP_SECT_ERASE, {6'h0, pa}, 3);
    m.desel();
    rdst();
    check(r, est() | 8'h01);
    cmd(1'b0, OP_READ, {6'h0, pa}, 3);
    m.desel();
    check(fq.size(), 1);
    wen = 0;
    idle();
    wren();
    emode = 1;
    fq.delete();
    pa = 18'($random(seed));
    cmd(1'b0, OP_SECT_ERASE, {6'h0, pa}, 3);
    m.desel();
    {werr, wen} = {32'd1, 32'd0};
    idle();
    rdst();
    check(r, est());
    check(fq[0][51:32], {FL_SERASE, pa[17:11], 11'h0});
    wren();
    fq.delete();
    cmd(1'b0, OP_BULK_ERASE, 24'h0, 0);
    m.desel();
    {werr, wen} = {32'd1, 32'd0};
    idle();
    check(fq[0][51:50], FL_BERASE);
    cmd(1'b0, OP_CHIP_RST, 24'h0, 0);
    m.desel();
    check({nrst, nclr}, {32'd1, 32'd1});
    rst(1'b1, 1'b0);
    rst(1'b0, 1'b1);
    rdst();
    check(r, est());
    fq.delete();
    rd(1'b0, 1'b0, 18'h00010, 1);
    check(fq.size(), 0);
    wren();
    cmd(1'b0, OP_WR_CFG, 24'h0, 0);
    tx(c);
    m.desel();
    wren();
    cmd(1'b0, OP_BULK_ERASE, 24'h0, 0);
    m.desel();
    {cfg, werr, wen} = {32'd1, 32'd1, 32'd0};
    idle();
    check(fq.size(), 1);
    tally_and_finish();
  end
  initial
  begin
    #1000000;
    errors++;
    tally_and_finish();
  end
endmodule
